//--- hw/srcr_pkg.sv
// Package with the register map, field positions, reset values and counts of the block
package srcr_pkg;

  // ****************************************************************
  // Register byte addresses
  // ****************************************************************
  localparam logic [11:0] ADDR_CLOCK_CONTROL_ZERO = 12'h029;
  localparam logic [11:0] ADDR_CLOCK_CONTROL_ONE  = 12'h02A;
  localparam logic [11:0] ADDR_CAPTURE_POS_0      = 12'h02C;
  localparam logic [11:0] ADDR_CAPTURE_POS_1      = 12'h02D;
  localparam logic [11:0] ADDR_CAPTURE_POS_2      = 12'h02E;
  localparam logic [11:0] ADDR_FULL_SCALE_A_LO    = 12'h030;
  localparam logic [11:0] ADDR_FULL_SCALE_A_HI    = 12'h031;
  localparam logic [11:0] ADDR_FULL_SCALE_B_LO    = 12'h032;
  localparam logic [11:0] ADDR_FULL_SCALE_B_HI    = 12'h033;
  localparam logic [11:0] ADDR_REFERENCE_BYPASS   = 12'h038;
  localparam logic [11:0] ADDR_TIMESTAMP_CTRL     = 12'h03B;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0]  RST_CLOCK_CONTROL_ZERO = 8'h00;
  localparam logic [7:0]  RST_CLOCK_CONTROL_ONE  = 8'h20;
  localparam logic [15:0] RST_FULL_SCALE         = 16'hA000;
  localparam logic [7:0]  RST_REFERENCE_BYPASS   = 8'h00;
  localparam logic [7:0]  RST_TIMESTAMP_CTRL     = 8'h00;
  localparam logic [23:0] RST_CAPTURE_POS        = 24'h000000;
  localparam logic [7:0]  READ_UNMAPPED          = 8'h00;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BIT_PROC_EN     = 6;
  localparam int BIT_RECV_EN     = 5;
  localparam int BIT_ZOOM        = 4;
  localparam int SEL_MSB         = 3;
  localparam int SEL_LSB         = 0;
  localparam int BIT_DEVICE_SAMPLE_CLOCK_PECL = 2;
  localparam int BIT_PULSE_PECL  = 1;
  localparam int BIT_INVERT      = 0;
  localparam int BIT_BYPASS      = 0;
  localparam int BIT_TS_EN       = 0;
  localparam int BIT_TS_PECL     = 1;

  // ****************************************************************
  // Delay line and capture sizes
  // ****************************************************************
  localparam int          TAP_COUNT    = 16;
  localparam logic [3:0]  SEL_AUTO     = 4'h0;
  localparam logic [3:0]  AUTO_TAP     = 4'h8;
  localparam int          POS_WIDTH    = 24;

endpackage

//--- hw/srcr_pos_tracker.sv
// Capture-position tracker: keeps a sample history and snaps it on each rising pulse edge
`timescale 1ns/1ps
`default_nettype none

module srcr_pos_tracker
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        sample,
  input  wire logic        zoom,
  output logic [23:0]      position,
  output logic             edge_seen
);

  typedef struct packed
  {
    logic [23:0] hist;
    logic [23:0] pos;
    logic        prev;
    logic        phase;
    logic        edge_seen;
  } srcr_trk_t;

  srcr_trk_t st_reg;
  srcr_trk_t st_next;

  // History shift and snapshot on a rising edge
  always_comb
  begin
    st_next = st_reg;
    st_next.prev = sample;
    st_next.phase = ~st_reg.phase;
    st_next.edge_seen = sample & ~st_reg.prev;
    // Zoom shifts every cycle; coarse view shifts every other cycle
    if (zoom || st_reg.phase)
    begin
      st_next.hist = {st_reg.hist[22:0], sample};
    end
    // Refresh the position on every new edge
    if (sample && !st_reg.prev)
    begin
      st_next.pos = {st_reg.hist[22:0], sample};
    end
  end

  // Register the whole state; clock enable freezes it
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_reg <= '{hist: 24'h000000, pos: srcr_pkg::RST_CAPTURE_POS, prev: 1'b0,
                  phase: 1'b0, edge_seen: 1'b0};
    end
    else if (ce)
    begin
      st_reg <= st_next;
    end
  end

  assign position  = st_reg.pos;
  assign edge_seen = st_reg.edge_seen;

endmodule
`default_nettype wire

//--- hw/srcr_regs.sv
// Reference-pulse, clock-input and full-scale register bank with pulse capture path
`timescale 1ns/1ps
`default_nettype none

module srcr_regs
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // Byte register port behind the serial configuration interface
  input  wire logic [11:0] cfg_addr,
  input  wire logic [7:0]  cfg_wdata,
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  output logic [7:0]       cfg_rdata,
  output logic             cfg_rvalid,
  // Reference pulse from its receiver pin, asynchronous to clk
  input  wire logic        refpulse_pin,
  // Steering outputs
  output logic             refpulse_receiver_enable,
  output logic             refpulse_processor_enable,
  output logic             refpulse_event,
  output logic [3:0]       refpulse_applied_tap,
  output logic             refpulse_auto_cal,
  output logic             device_clock_pecl_mode,
  output logic             refpulse_pecl_mode,
  output logic             refpulse_polarity_invert,
  output logic [15:0]      input_a_full_scale,
  output logic [15:0]      input_b_full_scale,
  output logic             reference_bypass,
  output logic             timestamp_input_enable,
  output logic             timestamp_input_pecl_mode
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed
  {
    logic        sync_a;
    logic        sync_b;
    logic [7:0]  ctrl0;
    logic [7:0]  ctrl1;
    logic [15:0] fs_a;
    logic [15:0] fs_b;
    logic [7:0]  bypass;
    logic [7:0]  tstamp;
    logic [14:0] dline;
    logic        tap_out;
    logic [7:0]  rdata;
    logic        rvalid;
    logic        event_p;
    logic [3:0]  tap;
    logic        auto_cal;
  } srcr_state_t;

  srcr_state_t st_reg;
  srcr_state_t st_next;

  logic [23:0] position;
  logic        edge_seen;
  logic        tap_sel_sample;
  logic [15:0] taps;

  // ****************************************************************
  // Capture position tracking
  // ****************************************************************
  // The tracker looks at the delayed, polarity-corrected and gated pulse
  srcr_pos_tracker u_tracker
  (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .sample    (st_reg.tap_out),
    .zoom      (st_reg.ctrl0[srcr_pkg::BIT_ZOOM]),
    .position  (position),
    .edge_seen (edge_seen)
  );

  // Tap 0 is the undelayed pulse; tap n is n cycles later
  assign taps = {st_reg.dline, st_reg.sync_b};

  // Pick the tap selected by the current applied delay
  assign tap_sel_sample = taps[st_reg.tap];

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb
  begin
    st_next = st_reg;
    st_next.rvalid = 1'b0;

    // Two-stage synchroniser; only the second stage is used downstream
    st_next.sync_a = refpulse_pin;
    // Second stage only; receiver gating and inversion are applied after alignment, at the delay line input
    st_next.sync_b = st_reg.sync_a;

    // Delay line fed with polarity and receiver gating applied
    st_next.dline = {st_reg.dline[13:0],
                     (st_reg.sync_b ^ st_reg.ctrl1[srcr_pkg::BIT_INVERT])
                     & st_reg.ctrl0[srcr_pkg::BIT_RECV_EN]};

    // The first dline stage is the gated input; tap 0 reads it
    st_next.tap_out = (st_reg.tap == 4'h0) ? st_reg.dline[0] : tap_sel_sample;

    // Delay selection: zero hands the choice to automatic calibration
    if (st_reg.ctrl0[srcr_pkg::SEL_MSB:srcr_pkg::SEL_LSB] == srcr_pkg::SEL_AUTO)
    begin
      st_next.tap = srcr_pkg::AUTO_TAP;
      st_next.auto_cal = 1'b1;
    end
    else
    begin
      st_next.tap = st_reg.ctrl0[srcr_pkg::SEL_MSB:srcr_pkg::SEL_LSB];
      st_next.auto_cal = 1'b0;
    end

    // Events only pass while processor and receiver are both on
    st_next.event_p = edge_seen
                      & st_reg.ctrl0[srcr_pkg::BIT_PROC_EN]
                      & st_reg.ctrl0[srcr_pkg::BIT_RECV_EN];

    // Register writes; the status bytes are read only and ignore writes
    if (cfg_wr)
    begin
      case (cfg_addr)
        srcr_pkg::ADDR_CLOCK_CONTROL_ZERO: st_next.ctrl0 = cfg_wdata;
        srcr_pkg::ADDR_CLOCK_CONTROL_ONE:  st_next.ctrl1 = cfg_wdata;
        srcr_pkg::ADDR_FULL_SCALE_A_LO:    st_next.fs_a[7:0] = cfg_wdata;
        srcr_pkg::ADDR_FULL_SCALE_A_HI:    st_next.fs_a[15:8] = cfg_wdata;
        srcr_pkg::ADDR_FULL_SCALE_B_LO:    st_next.fs_b[7:0] = cfg_wdata;
        srcr_pkg::ADDR_FULL_SCALE_B_HI:    st_next.fs_b[15:8] = cfg_wdata;
        srcr_pkg::ADDR_REFERENCE_BYPASS:   st_next.bypass = cfg_wdata;
        srcr_pkg::ADDR_TIMESTAMP_CTRL:     st_next.tstamp = cfg_wdata;
        default:
        begin
          st_next.ctrl0 = st_reg.ctrl0;
        end
      endcase
    end

    // Register reads answer one cycle later; unmapped bytes read zero
    if (cfg_rd)
    begin
      st_next.rvalid = 1'b1;
      case (cfg_addr)
        srcr_pkg::ADDR_CLOCK_CONTROL_ZERO: st_next.rdata = st_reg.ctrl0;
        srcr_pkg::ADDR_CLOCK_CONTROL_ONE:  st_next.rdata = st_reg.ctrl1;
        srcr_pkg::ADDR_CAPTURE_POS_0:      st_next.rdata = position[7:0];
        srcr_pkg::ADDR_CAPTURE_POS_1:      st_next.rdata = position[15:8];
        srcr_pkg::ADDR_CAPTURE_POS_2:      st_next.rdata = position[23:16];
        srcr_pkg::ADDR_FULL_SCALE_A_LO:    st_next.rdata = st_reg.fs_a[7:0];
        srcr_pkg::ADDR_FULL_SCALE_A_HI:    st_next.rdata = st_reg.fs_a[15:8];
        srcr_pkg::ADDR_FULL_SCALE_B_LO:    st_next.rdata = st_reg.fs_b[7:0];
        srcr_pkg::ADDR_FULL_SCALE_B_HI:    st_next.rdata = st_reg.fs_b[15:8];
        srcr_pkg::ADDR_REFERENCE_BYPASS:   st_next.rdata = st_reg.bypass;
        srcr_pkg::ADDR_TIMESTAMP_CTRL:     st_next.rdata = st_reg.tstamp;
        default:                           st_next.rdata = srcr_pkg::READ_UNMAPPED;
      endcase
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Clock enable low freezes everything, including the synchroniser
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_reg <= '{sync_a: 1'b0, sync_b: 1'b0,
                  ctrl0: srcr_pkg::RST_CLOCK_CONTROL_ZERO,
                  ctrl1: srcr_pkg::RST_CLOCK_CONTROL_ONE,
                  fs_a: srcr_pkg::RST_FULL_SCALE,
                  fs_b: srcr_pkg::RST_FULL_SCALE,
                  bypass: srcr_pkg::RST_REFERENCE_BYPASS,
                  tstamp: srcr_pkg::RST_TIMESTAMP_CTRL,
                  dline: 15'h0000, tap_out: 1'b0,
                  rdata: 8'h00, rvalid: 1'b0, event_p: 1'b0,
                  tap: srcr_pkg::AUTO_TAP, auto_cal: 1'b1};
    end
    else if (ce)
    begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // Outputs, all straight from the state register
  // ****************************************************************
  assign cfg_rdata                 = st_reg.rdata;
  assign cfg_rvalid                = st_reg.rvalid;
  assign refpulse_receiver_enable  = st_reg.ctrl0[srcr_pkg::BIT_RECV_EN];
  assign refpulse_processor_enable = st_reg.ctrl0[srcr_pkg::BIT_PROC_EN];
  assign refpulse_event            = st_reg.event_p;
  assign refpulse_applied_tap      = st_reg.tap;
  assign refpulse_auto_cal         = st_reg.auto_cal;
  assign device_clock_pecl_mode    = st_reg.ctrl1[srcr_pkg::BIT_DEVICE_SAMPLE_CLOCK_PECL];
  assign refpulse_pecl_mode        = st_reg.ctrl1[srcr_pkg::BIT_PULSE_PECL];
  assign refpulse_polarity_invert  = st_reg.ctrl1[srcr_pkg::BIT_INVERT];
  // Codes pass as written; range mapping is analog and identical for both inputs
  assign input_a_full_scale        = st_reg.fs_a;
  assign input_b_full_scale        = st_reg.fs_b;
  assign reference_bypass          = st_reg.bypass[srcr_pkg::BIT_BYPASS];
  assign timestamp_input_enable    = st_reg.tstamp[srcr_pkg::BIT_TS_EN];
  assign timestamp_input_pecl_mode = st_reg.tstamp[srcr_pkg::BIT_TS_PECL];

endmodule
`default_nettype wire

//--- tb/srcr_checker.sv
// Checker for the pulse, clock-input and full-scale register bank
`timescale 1ns/1ps
`default_nettype none

module srcr_checker
(
  input wire logic        clk, rst, ce, cfg_wr, cfg_rd, cfg_rvalid, refpulse_pin,
  input wire logic [11:0] cfg_addr,
  input wire logic [7:0]  cfg_wdata, cfg_rdata,
  input wire logic        refpulse_receiver_enable, refpulse_processor_enable, refpulse_event,
  input wire logic [3:0]  refpulse_applied_tap,
  input wire logic        refpulse_auto_cal, device_clock_pecl_mode, refpulse_pecl_mode,
  input wire logic        refpulse_polarity_invert, reference_bypass,
  input wire logic [15:0] input_a_full_scale, input_b_full_scale,
  input wire logic        timestamp_input_enable, timestamp_input_pecl_mode
);
  // ****************************************************************
  // Properties on the register port
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic wr_ok;

  // Write strobe only counts on a running edge
  assign wr_ok = ce && cfg_wr;

  chk_read_answer: assert property (ce && cfg_rd |=> cfg_rvalid)
    else $error("read got no answer");
  chk_ctrl0_enables: assert property (wr_ok && cfg_addr == srcr_pkg::ADDR_CLOCK_CONTROL_ZERO
    |=> refpulse_processor_enable == $past(cfg_wdata[6])
    && refpulse_receiver_enable == $past(cfg_wdata[5]))
    else $error("enable bits not taken");
  // The applied tap is registered from the stored field, so it lands one cycle later
  chk_manual_tap: assert property (wr_ok && cfg_addr == srcr_pkg::ADDR_CLOCK_CONTROL_ZERO
    && cfg_wdata[3:0] != 4'h0 |=> ##1 refpulse_applied_tap == $past(cfg_wdata[3:0], 2)
    && !refpulse_auto_cal)
    else $error("manual tap wrong");
  chk_auto_select: assert property (wr_ok && cfg_addr == srcr_pkg::ADDR_CLOCK_CONTROL_ZERO
    && cfg_wdata[3:0] == 4'h0 |=> ##1 refpulse_auto_cal)
    else $error("auto calibration not chosen");
  chk_auto_tap: assert property (refpulse_auto_cal |-> refpulse_applied_tap == srcr_pkg::AUTO_TAP)
    else $error("auto tap wrong");
  chk_event_gated: assert property (refpulse_event
    |-> $past(refpulse_processor_enable) && $past(refpulse_receiver_enable))
    else $error("event while disabled");
  chk_ctrl1_modes: assert property (wr_ok && cfg_addr == srcr_pkg::ADDR_CLOCK_CONTROL_ONE
    |=> {device_clock_pecl_mode, refpulse_pecl_mode, refpulse_polarity_invert}
    == $past(cfg_wdata[2:0]))
    else $error("clock one modes wrong");
  chk_fs_a_low: assert property (wr_ok && cfg_addr == srcr_pkg::ADDR_FULL_SCALE_A_LO
    |=> input_a_full_scale[7:0] == $past(cfg_wdata))
    else $error("range A low byte wrong");
  chk_fs_b_high: assert property (wr_ok && cfg_addr == srcr_pkg::ADDR_FULL_SCALE_B_HI
    |=> input_b_full_scale[15:8] == $past(cfg_wdata))
    else $error("range B high byte wrong");
  chk_bypass_bit: assert property (wr_ok && cfg_addr == srcr_pkg::ADDR_REFERENCE_BYPASS
    |=> reference_bypass == $past(cfg_wdata[0]))
    else $error("bypass bit wrong");
  chk_stamp_bits: assert property (wr_ok && cfg_addr == srcr_pkg::ADDR_TIMESTAMP_CTRL
    |=> {timestamp_input_pecl_mode, timestamp_input_enable} == $past(cfg_wdata[1:0]))
    else $error("timestamp bits wrong");
  chk_reset_codes: assert property (disable iff (1'b0) rst && ce |=> input_a_full_scale
    == srcr_pkg::RST_FULL_SCALE && input_b_full_scale == srcr_pkg::RST_FULL_SCALE)
    else $error("range reset wrong");
endmodule

bind srcr_regs srcr_checker u_chk (.clk(clk), .rst(rst), .ce(ce), .cfg_wr(cfg_wr),
  .cfg_rd(cfg_rd), .cfg_rvalid(cfg_rvalid), .refpulse_pin(refpulse_pin), .cfg_addr(cfg_addr),
  .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .refpulse_receiver_enable(refpulse_receiver_enable),
  .refpulse_processor_enable(refpulse_processor_enable), .refpulse_event(refpulse_event),
  .refpulse_applied_tap(refpulse_applied_tap), .refpulse_auto_cal(refpulse_auto_cal),
  .device_clock_pecl_mode(device_clock_pecl_mode), .refpulse_pecl_mode(refpulse_pecl_mode),
  .refpulse_polarity_invert(refpulse_polarity_invert), .reference_bypass(reference_bypass),
  .input_a_full_scale(input_a_full_scale), .input_b_full_scale(input_b_full_scale),
  .timestamp_input_enable(timestamp_input_enable),
  .timestamp_input_pecl_mode(timestamp_input_pecl_mode));
`default_nettype wire

//--- tb/srcr_host.sv
// Configuration host model that drives the byte register port
`timescale 1ns/1ps
`default_nettype none

module srcr_host
(
  input  wire logic        clk,
  input  wire logic [7:0]  cfg_rdata,
  input  wire logic        cfg_rvalid,
  output logic [11:0]      cfg_addr = 12'h000,
  output logic [7:0]       cfg_wdata = 8'h00,
  output logic             cfg_wr = 1'b0,
  output logic             cfg_rd = 1'b0
);
  // One byte write cycle; the strobe stands for exactly one sampled edge
  task automatic put(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    cfg_addr  <= a;
    cfg_wdata <= d;
    cfg_wr    <= 1'b1;
    @(posedge clk);
    cfg_wr    <= 1'b0;
    cfg_addr  <= ~a;
    cfg_wdata <= ~d;
  endtask

  // One byte write; the value is bent to what a careful host may send
  task automatic wr(input logic [11:0] a, inout logic [7:0] d);
    if ((a == srcr_pkg::ADDR_FULL_SCALE_A_HI || a == srcr_pkg::ADDR_FULL_SCALE_B_HI) && d < 8'h20)
      d[5] = 1'b1;
    // Receiver goes on in a write of its own before the processor follows
    if (a == srcr_pkg::ADDR_CLOCK_CONTROL_ZERO && d[6])
    begin
      d[5] = 1'b1;
      put(a, d & 8'hBF);
    end
    put(a, d);
  endtask

  // One byte read; data is taken once the registered answer has landed
  task automatic rd(input logic [11:0] a, output logic [7:0] d, output logic ok);
    @(posedge clk);
    cfg_addr <= a;
    cfg_rd   <= 1'b1;
    @(posedge clk);
    cfg_rd   <= 1'b0;
    cfg_addr <= ~a;
    #1;
    d  = cfg_rdata;
    ok = cfg_rvalid;
  endtask
endmodule
`default_nettype wire

//--- tb/tb_sysref_clock_range_regs.sv
// Self-checking bench for the pulse, clock-input and full-scale register bank
`timescale 1ns/1ps
`default_nettype none

module tb_sysref_clock_range_regs;
  logic        clk = 1'b0, rst = 1'b1, ce = 1'b1, pin = 1'b0, wr, rd, rvalid, ok;
  logic [11:0] addr;
  logic [7:0]  wdata, rdata, v, d;
  logic        recv, proc, ev, auto, dpecl, ppecl, inv, byp, tsen, tspecl;
  logic [3:0]  tap;
  logic [15:0] fsa, fsb;
  logic [7:0]  mdl [0:63];
  logic [11:0] rw [8] = '{12'h029, 12'h02A, 12'h030, 12'h031, 12'h032, 12'h033, 12'h038, 12'h03B};
  logic [7:0]  modes [4] = '{8'h23, 8'h63, 8'h70, 8'h00};
  int          mismatches = 0, checks_done = 0, events = 0, i;

  // Free-running clock and an event counter sampled on every rising edge
  always #5 clk = ~clk;
  always @(posedge clk) if (ev === 1'b1) events <= events + 1;

  srcr_host host (.clk(clk), .cfg_rdata(rdata), .cfg_rvalid(rvalid), .cfg_addr(addr),
    .cfg_wdata(wdata), .cfg_wr(wr), .cfg_rd(rd));
  srcr_regs dut (.clk(clk), .rst(rst), .ce(ce), .cfg_addr(addr), .cfg_wdata(wdata), .cfg_wr(wr),
    .cfg_rd(rd), .cfg_rdata(rdata), .cfg_rvalid(rvalid), .refpulse_pin(pin),
    .refpulse_receiver_enable(recv), .refpulse_processor_enable(proc), .refpulse_event(ev),
    .refpulse_applied_tap(tap), .refpulse_auto_cal(auto), .device_clock_pecl_mode(dpecl),
    .refpulse_pecl_mode(ppecl), .refpulse_polarity_invert(inv), .input_a_full_scale(fsa),
    .input_b_full_scale(fsb), .reference_bypass(byp), .timestamp_input_enable(tsen),
    .timestamp_input_pecl_mode(tspecl));

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Writes go to the model only where a stored register lives
  task automatic wr_mdl(input logic [11:0] a, input logic [7:0] x);
    d = x;
    host.wr(a, d);
    foreach (rw[k]) if (rw[k] == a) mdl[a[5:0]] = d;
  endtask

  task automatic rd_chk(input logic [11:0] a);
    host.rd(a, v, ok);
    check(ok, 1'b1, "read answer");
    check(v, mdl[a[5:0]], "read data");
  endtask

  // Model image after reset: everything zero but the reset codes
  task automatic mdl_reset;
    foreach (mdl[k]) mdl[k] = 8'h00;
    mdl[6'h2A] = srcr_pkg::RST_CLOCK_CONTROL_ONE;
    mdl[6'h31] = srcr_pkg::RST_FULL_SCALE[15:8];
    mdl[6'h33] = srcr_pkg::RST_FULL_SCALE[15:8];
  endtask

  // Outputs are compared once the write edge has passed
  task automatic check_outs;
    @(posedge clk);
    #1;
    check({proc, recv}, mdl[6'h29][6:5], "enables");
    check(auto, mdl[6'h29][3:0] == 4'h0, "auto cal");
    check(tap, (mdl[6'h29][3:0] == 4'h0) ? srcr_pkg::AUTO_TAP : mdl[6'h29][3:0], "tap");
    check({dpecl, ppecl, inv}, mdl[6'h2A][2:0], "clock modes");
    check(fsa, {mdl[6'h31], mdl[6'h30]}, "range A");
    check(fsb, {mdl[6'h33], mdl[6'h32]}, "range B");
    check({tspecl, tsen, byp}, {mdl[6'h3B][1:0], mdl[6'h38][0]}, "bypass and stamp");
  endtask

  task automatic finish_test;
    $display("TB counts: %0d checks, %0d mismatches", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Watchdog well beyond the several hundred cycles the tests need
  initial
  begin
    #200000;
    mismatches++;
    finish_test;
  end

  initial
  begin
    i = $urandom(32'h8B97);
    mdl_reset;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    // Reset image over the whole span, holes and capture position included
    for (i = 12'h028; i < 12'h03D; i++) rd_chk(12'(i));
    check_outs;
    $display("TB test reset values done");
    // Capture position and holes ignore writes
    for (i = 12'h02B; i < 12'h030; i++) wr_mdl(12'(i), 8'hFF);
    for (i = 12'h02B; i < 12'h030; i++) rd_chk(12'(i));
    $display("TB test read-only writes done");
    // Random contents in every stored register, read back and steered
    repeat (4)
    begin
      foreach (rw[k]) wr_mdl(rw[k], 8'($urandom));
      foreach (rw[k]) rd_chk(rw[k]);
      check_outs;
    end
    $display("TB test random contents done");
    // Clock enable low freezes the bank, so a write in that span is lost
    ce <= 1'b0;
    d = ~mdl[6'h30];
    host.wr(srcr_pkg::ADDR_FULL_SCALE_A_LO, d);
    ce <= 1'b1;
    rd_chk(srcr_pkg::ADDR_FULL_SCALE_A_LO);
    $display("TB test clock enable done");
    // Mid-run reset returns every stored register and clears the pulse history
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    mdl_reset;
    foreach (rw[k]) rd_chk(rw[k]);
    check_outs;
    $display("TB test mid-run reset done");
    // Pulse gating: processor off, on, on with zoom and auto tap, receiver off
    wr_mdl(12'h02A, 8'h00);
    foreach (modes[m])
    begin
      wr_mdl(12'h029, modes[m]);
      repeat (40) @(posedge clk);
      events = 0;
      pin <= 1'b1;
      repeat (4) @(posedge clk);
      pin <= 1'b0;
      repeat (40) @(posedge clk);
      check(events, (m == 1 || m == 2) ? 16'd1 : 16'd0, "event count");
      // A lone edge after a quiet history snaps to a single one in the lowest bit;
      // with the receiver off the last snapshot stays frozen
      for (i = 0; i < 3; i++)
      begin
        host.rd(srcr_pkg::ADDR_CAPTURE_POS_0 + 12'(i), v, ok);
        check(v, (i == 0) ? 16'h0001 : 16'h0000, "position byte");
      end
    end
    $display("TB test pulse gating done");
    finish_test;
  end
endmodule
`default_nettype wire
